// ==== core/orx_pkg.sv ====
package orx_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W   = 13;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic       ZERO_RST = 1'b0;
   localparam logic       MIE_RST  = 1'b0;
   localparam logic [PC_W-1:0] IRQ_VECTOR_RST = 13'h0004;
   localparam logic [7:0]      MEMWR_RST      = 8'h00;
   localparam logic [PC_W-1:0] PCVAL_RST      = 13'h0000;
   localparam logic            PULSE_RST      = 1'b0;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_OR_MEM_ACC,
      OP_OR_IMM_ACC,
      OP_OR_INTO_MEM,
      OP_SUB_EXIT,
      OP_SUB_EXIT_LOAD_ACC,
      OP_IRQ_EXIT_REENABLE
   } orx_op_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_IRQ_TAKE
   } orx_state_t;

   localparam orx_state_t STATE_RST = ST_RUN;
endpackage

// ==== core/orx_alu_if.sv ====
`timescale 1ns/1ps
// carries the or unit's operands and result between core and alu
interface orx_alu_if;
   logic [7:0] opA;
   logic [7:0] opB;
   logic [7:0] result;
   logic       isZero;
   modport core (output opA, output opB, input result, input isZero);
   modport alu  (input opA, input opB, output result, output isZero);
endinterface

// ==== core/orx_or_alu.sv ====
`timescale 1ns/1ps
module orx_or_alu
   import orx_pkg::*;
(
   orx_alu_if.alu alu
);
   // pure combinational or with zero detect
   assign alu.result = alu.opA | alu.opB;
   assign alu.isZero = (alu.result == 8'h00);
endmodule

// ==== core/orx_exec.sv ====
`timescale 1ns/1ps
module orx_exec
   import orx_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst_b,
   input  wire logic            clkEn,
   input  wire logic            opValid,
   input  wire orx_op_t         opCode,
   input  wire logic [7:0]      immData,
   input  wire logic [7:0]      memRdData,
   input  wire logic [PC_W-1:0] stackTop,
   input  wire logic [PC_W-1:0] irqVector,
   input  wire logic            irqPending,
   output logic [7:0]           acc,
   output logic                 zeroFlag,
   output logic                 masterIrqEnable,
   output logic [7:0]           memWrData,
   output logic                 memWrEn,
   output logic                 stackPop,
   output logic                 pcLoad,
   output logic [PC_W-1:0]      pcLoadValue,
   output logic                 irqTaken
);
   ////////////////////////////////////////////////////////////////////////////
   orx_alu_if aluBus();

   logic [7:0]      acc_reg, acc_next;
   logic            zero_reg, zero_next;
   logic            mie_reg, mie_next;
   logic [7:0]      memWr_reg, memWr_next;
   logic            memWrEn_reg, memWrEn_next;
   logic            pop_reg, pop_next;
   logic            pcLoad_reg, pcLoad_next;
   logic [PC_W-1:0] pcVal_reg, pcVal_next;
   orx_state_t      state_reg, state_next;

   orx_or_alu uAlu (
      .alu (aluBus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // opcode classes; the or and exit classes feed the take gate, while the decode cases on opCode itself
   function automatic logic isOrCode(input orx_op_t code);
      return (code == OP_OR_MEM_ACC) || (code == OP_OR_IMM_ACC) || (code == OP_OR_INTO_MEM);
   endfunction

   function automatic logic isExitCode(input orx_op_t code);
      return (code == OP_SUB_EXIT) || (code == OP_SUB_EXIT_LOAD_ACC) || (code == OP_IRQ_EXIT_REENABLE);
   endfunction

   // only the immediate or takes its second operand from the instruction word
   function automatic logic usesImmOperand(input orx_op_t code);
      return code == OP_OR_IMM_ACC;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // operand select: immediate form uses the instruction byte
   wire isImm     = usesImmOperand(opCode);
   wire isOrOp    = opValid && isOrCode(opCode);
   wire isReturn  = opValid && isExitCode(opCode);
   wire isIrqExit = opValid && (opCode == OP_IRQ_EXIT_REENABLE);
   assign aluBus.opA = acc_reg;
   assign aluBus.opB = isImm ? immData : memRdData;

   // the shared or result and its zero test feed both the accumulator and the memory write path
   wire [7:0]      orResult   = aluBus.result;
   wire            orZero     = aluBus.isZero;
   // every return form takes the same address off the stack top
   wire [PC_W-1:0] returnAddr = stackTop;

   // mie as it stands after this cycle's instruction; the exit sets it so a pending request is taken next
   wire mieAfter = isIrqExit ? 1'b1 : mie_reg;
   // global gate: nothing is taken while the master enable is clear; an instruction in flight keeps
   // its slot, so a request simply waits for the next cycle without an or or a return in it
   wire takeIrq  = irqPending && mie_reg && !isOrOp && !isReturn;

   ////////////////////////////////////////////////////////////////////////////
   // next-state decode for one instruction
   always_comb begin
      acc_next     = acc_reg;
      zero_next    = zero_reg;
      mie_next     = mieAfter;
      memWr_next   = memWr_reg;
      memWrEn_next = 1'b0;
      pop_next     = 1'b0;
      pcLoad_next  = 1'b0;
      pcVal_next   = pcVal_reg;
      if (opValid) begin
         case (opCode)
            // both accumulator forms write the or result and its zero test
            OP_OR_MEM_ACC, OP_OR_IMM_ACC: begin
               acc_next  = orResult;
               zero_next = orZero;
            end
            // result goes back to memory only; the accumulator keeps its value
            OP_OR_INTO_MEM: begin
               memWr_next   = orResult;
               memWrEn_next = 1'b1;
               zero_next    = orZero;
            end
            // the three returns share the pop and the pc load and leave the zero flag alone
            OP_SUB_EXIT: begin
               pop_next    = 1'b1;
               pcLoad_next = 1'b1;
               pcVal_next  = returnAddr;
            end
            OP_SUB_EXIT_LOAD_ACC: begin
               pop_next    = 1'b1;
               pcLoad_next = 1'b1;
               pcVal_next  = returnAddr;
               acc_next    = immData;
            end
            OP_IRQ_EXIT_REENABLE: begin
               pop_next    = 1'b1;
               pcLoad_next = 1'b1;
               pcVal_next  = returnAddr;
            end
            // no-operation code: everything holds
            default: begin
               acc_next = acc_reg;
            end
         endcase
      end
      // a request still pending after irq_exit_reenable takes the next slot that has no or or return in it
      if (takeIrq) begin
         pcLoad_next = 1'b1;
         pcVal_next  = irqVector;
         mie_next    = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // take tracker: a take slot lasts one enabled cycle, and irqTaken shows exactly that slot
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (takeIrq) begin
               state_next = ST_IRQ_TAKE;
            end
         end
         ST_IRQ_TAKE: begin
            // the take cleared mie, so in practice the tracker drops straight back to run
            state_next = takeIrq ? ST_IRQ_TAKE : ST_RUN;
         end
         default: begin
            state_next = STATE_RST;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator and zero flag; clkEn low freezes them with the rest of the state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         acc_reg  <= ACC_RST;
         zero_reg <= ZERO_RST;
      end else if (clkEn) begin
         acc_reg  <= acc_next;
         zero_reg <= zero_next;
      end
   end

   // master enable; it comes up cleared so nothing is taken before software opens the gate
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mie_reg <= MIE_RST;
      end else if (clkEn) begin
         mie_reg <= mie_next;
      end
   end

   // memory write port, used by or_into_memory alone
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         memWr_reg   <= MEMWR_RST;
         memWrEn_reg <= PULSE_RST;
      end else if (clkEn) begin
         memWr_reg   <= memWr_next;
         memWrEn_reg <= memWrEn_next;
      end
   end

   // stack pop and program counter load; a frozen cycle holds a pulse rather than dropping it,
   // so whatever consumes these pulses has to stall on the same enable
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pop_reg    <= PULSE_RST;
         pcLoad_reg <= PULSE_RST;
         pcVal_reg  <= PCVAL_RST;
      end else if (clkEn) begin
         pop_reg    <= pop_next;
         pcLoad_reg <= pcLoad_next;
         pcVal_reg  <= pcVal_next;
      end
   end

   // take tracker register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= STATE_RST;
      end else if (clkEn) begin
         state_reg <= state_next;
      end
   end

   // architectural state straight from flops
   assign acc             = acc_reg;
   assign zeroFlag        = zero_reg;
   assign masterIrqEnable = mie_reg;

   // memory write side
   assign memWrData       = memWr_reg;
   assign memWrEn         = memWrEn_reg;

   // flow pulses; irqTaken decodes the tracker flop, so it still changes only on the clock
   assign stackPop        = pop_reg;
   assign pcLoad          = pcLoad_reg;
   assign pcLoadValue     = pcVal_reg;
   assign irqTaken        = (state_reg == ST_IRQ_TAKE);
endmodule

// ==== tb/orx_exec_chk.sv ====
`timescale 1ns/1ps
module orx_exec_chk
   import orx_pkg::*;
(
   input logic            mclk,
   input logic            rst_b,
   input logic            clkEn,
   input logic            opValid,
   input orx_op_t         opCode,
   input logic [7:0]      immData,
   input logic [7:0]      memRdData,
   input logic [PC_W-1:0] stackTop,
   input logic [PC_W-1:0] irqVector,
   input logic            irqPending,
   input logic [7:0]      acc,
   input logic            zeroFlag,
   input logic            masterIrqEnable,
   input logic [7:0]      memWrData,
   input logic            memWrEn,
   input logic            stackPop,
   input logic            pcLoad,
   input logic [PC_W-1:0] pcLoadValue,
   input logic            irqTaken
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // an op is only taken with the clock enable high
   wire goNow = clkEn && opValid;
   wire isOr  = opCode == OP_OR_MEM_ACC || opCode == OP_OR_IMM_ACC || opCode == OP_OR_INTO_MEM;
   AST_OR_MEM: assert property (goNow && opCode == OP_OR_MEM_ACC |=> acc == ($past(acc) | $past(memRdData)))
      else $error("or memory into acc wrong");
   AST_OR_IMM: assert property (goNow && opCode == OP_OR_IMM_ACC |=> acc == ($past(acc) | $past(immData)))
      else $error("or immediate into acc wrong");
   AST_OR_INTO: assert property (goNow && opCode == OP_OR_INTO_MEM |=> memWrEn && $stable(acc)
      && memWrData == ($past(acc) | $past(memRdData))) else $error("or into memory wrong");
   AST_SUB_EXIT: assert property (goNow && opCode == OP_SUB_EXIT |=> stackPop && pcLoad
      && pcLoadValue == $past(stackTop) && $stable(zeroFlag)) else $error("subroutine exit wrong");
   AST_EXIT_ACC: assert property (goNow && opCode == OP_SUB_EXIT_LOAD_ACC |=> stackPop
      && acc == $past(immData) && $stable(zeroFlag)) else $error("exit with acc load wrong");
   AST_IRQ_EXIT: assert property (goNow && opCode == OP_IRQ_EXIT_REENABLE |=> stackPop
      && masterIrqEnable && $stable(zeroFlag)) else $error("irq exit wrong");
   AST_PEND: assert property (goNow && opCode == OP_IRQ_EXIT_REENABLE ##1 clkEn && irqPending && !opValid
      |=> irqTaken && pcLoadValue == $past(irqVector)) else $error("pending irq not taken");
   AST_GATE: assert property (!masterIrqEnable && clkEn |=> !irqTaken) else $error("irq taken while gated");
   AST_ZERO: assert property (goNow && isOr
      |=> zeroFlag == (($past(acc) | ($past(opCode) == OP_OR_IMM_ACC ? $past(immData)
      : $past(memRdData))) == 8'h00))
      else $error("zero flag wrong");
   COV_OR: cover property (goNow && isOr);
   COV_EXIT: cover property (goNow && opCode == OP_SUB_EXIT_LOAD_ACC);
   COV_TAKE: cover property (irqTaken);
endmodule
////////////////////////////////////////////////////////////////////////
bind orx_exec orx_exec_chk orx_exec_chk_inst (.*);

// ==== tb/or_and_return_instructions_tb.sv ====
`timescale 1ns/1ps
module or_and_return_instructions_tb;
   import orx_pkg::*;
   logic            mclk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, opValid = 1'b0, irqPending = 1'b0;
   orx_op_t         opCode = OP_NONE;
   logic [7:0]      immData = 8'h00, memRdData = 8'h00, acc, memWrData;
   logic [PC_W-1:0] stackTop = 13'h0000, irqVector = 13'h0004, pcLoadValue;
   logic            zeroFlag, masterIrqEnable, memWrEn, stackPop, pcLoad, irqTaken;
   int              mismatches = 0, numChecks = 0, cycles = 0;
   orx_exec orx_exec_inst (.*);
   ////////////////////////////////////////////////////////////////////////
   // clock, and a ceiling far above the few dozen cycles the run needs
   initial begin
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task chk(input string n, input logic [23:0] e, input logic [23:0] s);
      numChecks++;
      if (e !== s) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // one op cycle; results land on the edge inside it, so read at the next fall
   task op(input orx_op_t c, input logic [7:0] im, input logic [7:0] m, input logic [12:0] st);
      @(negedge mclk);
      opValid = 1'b1;
      opCode = c;
      immData = im;
      memRdData = m;
      stackTop = st;
      @(negedge mclk);
      opValid = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // zero is set first so that a return that touches flags shows up
   task t_exit;
      op(OP_OR_IMM_ACC, 8'h00, 8'h00, 13'h0000);
      chk("zeroset", {8'h00, 1'b1}, {acc, zeroFlag});
      op(OP_SUB_EXIT, 8'h00, 8'h00, 13'h1234);
      chk("subexit", {2'b11, 13'h1234, 1'b1}, {stackPop, pcLoad, pcLoadValue, zeroFlag});
      op(OP_SUB_EXIT_LOAD_ACC, 8'h5a, 8'h00, 13'h0321);
      chk("exitacc", {1'b1, 13'h0321, 8'h5a, 1'b1}, {stackPop, pcLoadValue, acc, zeroFlag});
   endtask
   task t_or;
      op(OP_OR_IMM_ACC, 8'h05, 8'h00, 13'h0000);
      chk("orimm", {8'h5f, 1'b0}, {acc, zeroFlag});
      op(OP_OR_MEM_ACC, 8'h00, 8'h80, 13'h0000);
      chk("ormem", 8'hdf, acc);
      // memory result differs from acc, so an accumulator write would show
      op(OP_OR_INTO_MEM, 8'h00, 8'h20, 13'h0000);
      chk("orinto", {8'hff, 1'b1, 8'hdf, 1'b0}, {memWrData, memWrEn, acc, zeroFlag});
   endtask
   task t_irq;
      irqPending = 1'b1;
      repeat (3) @(negedge mclk);
      chk("gated", 1'b0, irqTaken);
      op(OP_IRQ_EXIT_REENABLE, 8'h00, 8'h00, 13'h0abc);
      chk("irqexit", {3'b111, 13'h0abc}, {stackPop, pcLoad, masterIrqEnable, pcLoadValue});
      @(negedge mclk);
      chk("take", {2'b11, 13'h0004, 1'b0}, {irqTaken, pcLoad, pcLoadValue, masterIrqEnable});
      // second exit, then the clock enable dropped for two cycles: the take must wait, then still come first
      op(OP_IRQ_EXIT_REENABLE, 8'h00, 8'h00, 13'h0def);
      clkEn = 1'b0;
      repeat (2) @(negedge mclk);
      chk("frozen", {1'b0, 1'b1, 13'h0def}, {irqTaken, masterIrqEnable, pcLoadValue});
      clkEn = 1'b1;
      @(negedge mclk);
      chk("latetake", {2'b11, 13'h0004, 1'b0}, {irqTaken, pcLoad, pcLoadValue, masterIrqEnable});
      irqPending = 1'b0;
   endtask
   task report_and_stop;
      if (mismatches == 0 && numChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      t_exit;
      t_or;
      t_irq;
      report_and_stop;
   end
endmodule
